// *** hdl/printer_lightpen_vsync_port.sv ***
// Behaviour
// RULE1: Select only for parallel slot in window
// RULE2: Host drives register select with select
// RULE3: All transitions on enable clock edges; the pen and video latches, the byte buffer and the sequencer's exit from idle change on any core clock edge
// RULE4: Write only with write-direction, else read
// RULE5: Host strobes write or data-in
// RULE6: Printer byte on A0-1, B2-7
// RULE7: Validate byte, pulse strobe low
// RULE8: Inverted acknowledge, programmable edge input
// RULE9: Acknowledge edge raises port B interrupt
// RULE10: Host reads control, then sends byte
// RULE11: Busy drives control input and A0
// RULE12: Host polls A0 until busy clears
// RULE13: Host pulses initialise line briefly
// RULE14: Host waits while error asserted
// RULE15: Leading pen edge sets latch
// RULE16: Pen latch drives controller strobe
// RULE17: Pen latch edge lowers port A interrupt
// RULE18: Host clears pen latch low
// RULE19: Inverted pen switch on A6
// RULE20: Vsync edge sets latch, interrupts
// RULE21: Host clears video latch via output
// RULE22: Latches hold until cleared low
`timescale 1ns/100ps
`default_nettype none
`include "pport_consts.svh"
module printer_lightpen_vsync_port
  import pport_pkg::*;
#(
  parameter int STROBE_LEN = 2
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       enable_clk,
  input  wire logic       io_cycle,
  input  wire logic [7:0] io_addr,
  input  wire logic       write_dir,
  input  wire logic       write_strobe,
  input  wire logic       data_in_strobe,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata,
  output logic            adapter_chip_select,
  output logic            porta_interrupt_out,
  output logic            portb_interrupt_out,
  output logic            display_interrupt,
  output logic            printer_interrupt,
  output logic      [7:0] printer_data_line,
  output logic            printer_strobe_n,
  output logic            printer_init_n,
  input  wire logic       printer_acknowledge,
  input  wire logic       ack_active_high,
  input  wire logic       printer_busy,
  input  wire logic       printer_error,
  input  wire logic       pen_pulse,
  input  wire logic       pen_trailing_jumper,
  input  wire logic       pen_switch_input,
  output logic            light_pen_strobe,
  input  wire logic       vertical_sync_pulse,
  output logic            data_ready,
  output logic            tx_valid,
  input  wire logic       tx_ready
);
  // Counter is four bits wide, and a zero length would wrap and stretch the strobe to 16 periods
  if (STROBE_LEN < 1 || STROBE_LEN > 15) begin
    $error("STROBE_LEN out of range");
  end
  byte_t ora;          // Port A output register
  byte_t orb;          // Port B output register
  byte_t cra;          // Port A control
  byte_t crb;          // Port B control
  logic  e_q;          // Enable clock, previous sample
  logic  e_rise;       // Enable rising edge
  logic  e_fall;       // Enable falling edge
  logic  pen_q;        // Pen pulse, previous sample
  logic  vs_q;         // Vsync, previous sample
  logic  pen_latch;    // Light pen event latch
  logic  vid_latch;    // Vertical sync latch
  logic  pen_lq;       // Pen latch at last enable edge
  logic  vid_lq;       // Video latch at last enable edge
  logic  cb1_q;        // Acknowledge control input, last edge
  logic  cb2_q;        // Busy control input, last edge
  logic  cb1_in;       // Acknowledge, inverted when ack_active_high is low
  logic  cb2_in;       // Buffered busy
  logic  access;       // Selected access on enable fall
  logic  wr_acc;       // Write access
  logic  rd_acc;       // Read access
  logic  port_b_wr;    // Port B data write, loads printer byte
  logic [1:0] rs;      // Register select
  byte_t buf_d [2];    // Two-entry printer byte buffer
  logic [1:0] buf_cnt; // Entries held
  logic  buf_wp;       // Write pointer
  logic  buf_rp;       // Read pointer
  strobe_state_t st;   // Strobe sequencer state
  logic [3:0] st_cnt;  // Strobe period counter

  // Port window and second decoder section slot
  // RULE1: chip select decode
  assign adapter_chip_select = io_cycle &&
    ((io_addr & `IO_RANGE_MASK) == `IO_RANGE_BASE) && (io_addr[4] == 1'b0) &&
    (io_addr[3:2] == `SLOT_PARALLEL);
  // RULE2: register select bits
  assign rs = io_addr[1:0];
  // RULE3: accesses land on enable fall
  assign access = adapter_chip_select && e_fall;
  // RULE4: write only with write direction
  assign wr_acc = access && write_dir && write_strobe;
  // RULE5: reads need data-in strobe
  assign rd_acc = access && !write_dir && data_in_strobe;
  // Port B write is refused while the buffer is full, so no buffered byte is overwritten
  assign port_b_wr = wr_acc && (rs == `RS_PORTB) && (buf_cnt != 2'd2);
  assign data_ready = (buf_cnt != 2'd2);

  // RULE8: acknowledge inverted when ack_active_high is low, before edge detect
  assign cb1_in = ack_active_high ? printer_acknowledge : !printer_acknowledge;
  // RULE11: busy feeds second port B input
  assign cb2_in = printer_busy;

  // Enable clock edge detection
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      e_q <= 1'b0;
    end else begin
      e_q <= enable_clk;
    end
  end
  assign e_rise = enable_clk && !e_q;
  assign e_fall = !enable_clk && e_q;

  // Light pen and video latches
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pen_q     <= 1'b0;
      vs_q      <= 1'b0;
      pen_latch <= 1'b0;
      vid_latch <= 1'b0;
    end else begin
      pen_q <= pen_pulse;
      vs_q  <= vertical_sync_pulse;
      // RULE15: leading edge, jumper picks trailing edge
      if (pen_trailing_jumper ? (!pen_pulse && pen_q) : (pen_pulse && !pen_q)) begin
        pen_latch <= 1'b1;
      // RULE22: hold until cleared low
      end else if (!ora[`PA_PCLEAR]) begin
        pen_latch <= 1'b0;
      end
      // RULE20: vsync rising edge sets latch
      if (vertical_sync_pulse && !vs_q) begin
        vid_latch <= 1'b1;
      // RULE22: hold until cleared low
      end else if (!ora[`PA_VCLEAR]) begin
        vid_latch <= 1'b0;
      end
    end
  end
  // RULE16: pen latch to controller strobe
  assign light_pen_strobe = pen_latch;

  // Control inputs sampled on enable rise; set beats read-clear
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cra    <= `CTRL_RESET;
      crb    <= `CTRL_RESET;
      pen_lq <= 1'b0;
      vid_lq <= 1'b0;
      cb1_q  <= 1'b0;
      cb2_q  <= 1'b0;
    end else begin
      if (wr_acc && rs == `RS_CTRLA) begin
        cra[5:0] <= wdata[5:0];
      end
      if (wr_acc && rs == `RS_CTRLB) begin
        crb[5:0] <= wdata[5:0];
      end
      // Reading the data register clears the flags
      if (rd_acc && rs == `RS_PORTA) begin
        cra[`CR_FLAG1] <= 1'b0;
        cra[`CR_FLAG2] <= 1'b0;
      end
      if (rd_acc && rs == `RS_PORTB) begin
        crb[`CR_FLAG1] <= 1'b0;
        crb[`CR_FLAG2] <= 1'b0;
      end
      if (e_rise) begin
        pen_lq <= pen_latch;
        vid_lq <= vid_latch;
        cb1_q  <= cb1_in;
        cb2_q  <= cb2_in;
        // RULE17: pen latch rising edge flag
        if (pen_latch && !pen_lq) begin
          cra[`CR_FLAG1] <= 1'b1;
        end
        // RULE20: video latch flag
        if (vid_latch && !vid_lq) begin
          cra[`CR_FLAG2] <= 1'b1;
        end
        // RULE8: programmable acknowledge edge
        if (crb[`CR_EDGE1_RISE] ? (cb1_in && !cb1_q) : (!cb1_in && cb1_q)) begin
          crb[`CR_FLAG1] <= 1'b1;
        end
        // RULE11: programmable busy edge
        if (crb[`CR_EDGE2_RISE] ? (cb2_in && !cb2_q) : (!cb2_in && cb2_q)) begin
          crb[`CR_FLAG2] <= 1'b1;
        end
      end
    end
  end

  // RULE17: masked port A interrupt, active low
  assign porta_interrupt_out = !((cra[`CR_FLAG1] && cra[`CR_IRQ1_EN]) ||
                                 (cra[`CR_FLAG2] && cra[`CR_IRQ2_EN]));
  assign display_interrupt = !porta_interrupt_out;
  // RULE9: port B interrupt on acknowledge
  assign portb_interrupt_out = !((crb[`CR_FLAG1] && crb[`CR_IRQ1_EN]) ||
                                 (crb[`CR_FLAG2] && crb[`CR_IRQ2_EN]));
  assign printer_interrupt = !portb_interrupt_out;

  // Port A output register, holds latch clears and initialise
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ora <= `PORTA_RESET;
    end else if (wr_acc && rs == `RS_PORTA) begin
      ora <= wdata;
    end
  end
  assign printer_init_n = !ora[`PA_INIT];

  // Two-entry buffer between host writes and the printer
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      buf_cnt  <= 2'd0;
      buf_wp   <= 1'b0;
      buf_rp   <= 1'b0;
      buf_d[0] <= `PORTB_RESET;
      buf_d[1] <= `PORTB_RESET;
      orb      <= `PORTB_RESET;
    end else begin
      if (port_b_wr) begin
        // RULE6: bits 0-1 from port A
        buf_d[buf_wp] <= {wdata[7:2], ora[`PA_DATA1], ora[`PA_DATA0]};
        buf_wp        <= !buf_wp;
        orb           <= wdata;
      end
      if (st == ST_IDLE && buf_cnt != 2'd0 && tx_ready) begin
        buf_rp <= !buf_rp;
      end
      case ({port_b_wr, st == ST_IDLE && buf_cnt != 2'd0 && tx_ready})
        2'b10:   buf_cnt <= buf_cnt + 2'd1;
        2'b01:   buf_cnt <= buf_cnt - 2'd1;
        default: buf_cnt <= buf_cnt;
      endcase
    end
  end
  assign tx_valid = (buf_cnt != 2'd0);

  // Strobe sequencer: data, valid, strobe low, hold
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st                <= ST_IDLE;
      st_cnt            <= 4'h0;
      printer_data_line <= 8'h00;
      printer_strobe_n  <= 1'b1;
    end else begin
      case (st)
        ST_IDLE: begin
          if (buf_cnt != 2'd0 && tx_ready) begin
            // RULE6: byte to printer lines
            printer_data_line <= buf_d[buf_rp];
            st                <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          // RULE3: strobe starts on enable rise
          if (e_rise) begin
            // RULE7: strobe low announces byte
            printer_strobe_n <= 1'b0;
            st_cnt           <= STROBE_LEN[3:0];
            st               <= ST_STROBE;
          end
        end
        ST_STROBE: begin
          if (e_rise) begin
            if (st_cnt == 4'h1) begin
              printer_strobe_n <= 1'b1;
              st               <= ST_HOLD;
            end else begin
              st_cnt <= st_cnt - 4'h1;
            end
          end
        end
        ST_HOLD: begin
          if (e_rise) begin
            st <= ST_IDLE;
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  // Read data, registered on selected read
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= 8'h00;
    end else if (rd_acc) begin
      case (rs)
        // RULE11: busy level on A0; RULE19: switch on A6
        `RS_PORTA: rdata <= {ora[7], !pen_switch_input, ora[5:4], printer_error,
                             ora[`PA_VALID], ora[1], printer_busy};
        `RS_CTRLA: rdata <= cra;
        `RS_PORTB: rdata <= orb;
        `RS_CTRLB: rdata <= crb;
        default:   rdata <= 8'h00;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** hdl/pport_consts.svh ***
`ifndef PPORT_CONSTS_SVH
`define PPORT_CONSTS_SVH
// Main-board I/O window and parallel slot code in second decoder section
`define IO_RANGE_BASE   8'hE0
`define IO_RANGE_MASK   8'hE0
`define SLOT_PARALLEL   2'h0
// Register select codes
`define RS_PORTA        2'h0
`define RS_CTRLA        2'h1
`define RS_PORTB        2'h2
`define RS_CTRLB        2'h3
// Control register fields
`define CR_IRQ1_EN      0
`define CR_EDGE1_RISE   1
`define CR_IRQ2_EN      3
`define CR_EDGE2_RISE   4
`define CR_FLAG2        6
`define CR_FLAG1        7
// Port A bit positions
`define PA_DATA0        0
`define PA_DATA1        1
`define PA_VALID        2
`define PA_VCLEAR       7
`define PA_SWITCH       6
`define PA_PCLEAR       5
`define PA_INIT         4
`define PA_ERROR        3
// Reset values
`define PORTA_RESET     8'hA0
`define PORTB_RESET     8'h00
`define CTRL_RESET      8'h00
// Strobe length in enable-clock periods
`define STROBE_CYCLES   4'h2
`endif

// *** hdl/pport_pkg.sv ***
`default_nettype none
package pport_pkg;
  // Strobe sequencer states
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SETUP  = 2'b01,
    ST_STROBE = 2'b10,
    ST_HOLD   = 2'b11
  } strobe_state_t;
  typedef logic [7:0] byte_t;
endpackage
`default_nettype wire

// *** tb/printer_side_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// Printer on the far side: takes bytes unless stalled, acknowledges each strobe
module printer_side_model (
  input  wire logic core_clk,
  input  wire logic printer_strobe_n,
  input  wire logic stall,
  input  wire logic ack_pol,
  output logic      printer_acknowledge,
  output logic      tx_ready
);
  logic [5:0] ack_cnt = 6'h00; // Countdown that places the ack pulse
  always_ff @(posedge core_clk) begin
    if (printer_strobe_n == 1'h0) begin
      ack_cnt <= 6'h28;
    end else if (ack_cnt != 6'h00) begin
      ack_cnt <= ack_cnt - 6'h01;
    end
  end
  // Pulse is longer than an enable period so it cannot slip between samples
  assign printer_acknowledge = (ack_cnt != 6'h00 && ack_cnt < 6'h18) ? ack_pol : !ack_pol;
  // Stall holds the byte stream back
  assign tx_ready = !stall;
endmodule
`default_nettype wire

// *** tb/pport_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module pport_props #(
  parameter int STROBE_LEN = 2
) (
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic       enable_clk,
  input wire logic       io_cycle,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] rdata,
  input wire logic       adapter_chip_select,
  input wire logic       porta_interrupt_out,
  input wire logic       portb_interrupt_out,
  input wire logic       display_interrupt,
  input wire logic       printer_interrupt,
  input wire logic [7:0] printer_data_line,
  input wire logic       printer_strobe_n,
  input wire logic       pen_pulse,
  input wire logic       pen_trailing_jumper,
  input wire logic       light_pen_strobe,
  input wire logic       data_ready,
  input wire logic       tx_valid
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  chk_select_decode: assert property (
    adapter_chip_select == (io_cycle && io_addr[7:2] == 6'h38)) else $error("bad decode");
  chk_disp_irq_inv: assert property (
    display_interrupt == !porta_interrupt_out) else $error("display irq not inverse");
  chk_prn_irq_inv: assert property (
    printer_interrupt == !portb_interrupt_out) else $error("printer irq not inverse");
  chk_pen_lead_set: assert property (
    $rose(pen_pulse) && !pen_trailing_jumper |-> ##[0:6] light_pen_strobe)
    else $error("pen latch not set");
  chk_pen_trail_set: assert property (
    $fell(pen_pulse) && pen_trailing_jumper |-> ##[0:6] light_pen_strobe)
    else $error("pen latch not set on trailing edge");
  chk_data_held: assert property (
    !printer_strobe_n |-> $stable(printer_data_line)) else $error("data moved in strobe");
  chk_strobe_width: assert property (
    $fell(printer_strobe_n) |=> !printer_strobe_n [*2]) else $error("strobe too short");
  chk_full_nonempty: assert property (
    !data_ready |-> tx_valid) else $error("full but empty");
  chk_read_timing: assert property (
    $changed(rdata) |-> ($past(enable_clk, 2) && !$past(enable_clk))
      || ($past(enable_clk, 3) && !$past(enable_clk, 2))) else $error("read off enable fall");
  cover property ($fell(printer_strobe_n));
  cover property (!data_ready);
  cover property ($rose(display_interrupt));
  cover property ($rose(printer_interrupt));
endmodule
`default_nettype wire

// *** tb/tb_printer_lightpen_vsync_port.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "pport_consts.svh"
module tb_printer_lightpen_vsync_port
  import pport_pkg::*;
;
  localparam int SL = 2; // Strobe length in enable periods
  logic core_clk = 1'h0, sys_rst = 1'h1, enable_clk = 1'h0, io_cycle = 1'h0;
  logic write_dir = 1'h0, write_strobe = 1'h0, data_in_strobe = 1'h0, stall = 1'h0;
  logic printer_busy = 1'h0, printer_error = 1'h0, pen_pulse = 1'h0, pen_switch_input = 1'h0;
  logic pen_trailing_jumper = 1'h0, vertical_sync_pulse = 1'h0, ack_active_high = 1'h1;
  logic [7:0] io_addr = 8'h00, wdata = 8'h00, rdata, printer_data_line;
  logic [2:0] ecnt = 3'h0; // Divider for the enable clock
  logic adapter_chip_select, porta_interrupt_out, portb_interrupt_out, display_interrupt;
  logic printer_interrupt, printer_strobe_n, printer_init_n, printer_acknowledge;
  logic light_pen_strobe, data_ready, tx_valid, tx_ready;
  int error_cnt = 0, num_checks = 0;
  byte_t q; // Discarded read data
  printer_lightpen_vsync_port #(.STROBE_LEN(SL)) dut_u (.core_clk, .sys_rst, .enable_clk,
    .io_cycle, .io_addr, .write_dir, .write_strobe, .data_in_strobe, .wdata, .rdata,
    .adapter_chip_select, .porta_interrupt_out, .portb_interrupt_out, .display_interrupt,
    .printer_interrupt, .printer_data_line, .printer_strobe_n, .printer_init_n,
    .printer_acknowledge, .ack_active_high, .printer_busy, .printer_error, .pen_pulse,
    .pen_trailing_jumper, .pen_switch_input, .light_pen_strobe, .vertical_sync_pulse,
    .data_ready, .tx_valid, .tx_ready);
  printer_side_model prn_u (.core_clk, .printer_strobe_n, .stall, .ack_pol(ack_active_high),
    .printer_acknowledge, .tx_ready);
  initial forever #5 core_clk = !core_clk;
  // Enable clock of eight core cycles, retimed to the core clock
  always @(posedge core_clk) begin
    ecnt <= ecnt + 3'h1;
    enable_clk <= ecnt[2];
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One access: held from an enable high phase through the falling edge
  task automatic acc(input logic [1:0] rs, input logic wr, input byte_t d, output byte_t r);
    @(posedge core_clk iff enable_clk === 1'h1);
    io_cycle <= 1'h1;
    io_addr <= {6'h38, rs};
    write_dir <= wr;
    write_strobe <= wr;
    data_in_strobe <= !wr;
    wdata <= d;
    @(posedge core_clk iff enable_clk === 1'h0);
    @(negedge core_clk);
    @(negedge core_clk);
    r = rdata;
    @(posedge core_clk);
    io_cycle <= 1'h0;
    write_strobe <= 1'h0;
    data_in_strobe <= 1'h0;
  endtask
  task automatic wr(input logic [1:0] rs, input byte_t d);
    acc(rs, 1'h1, d, q);
  endtask
  task automatic rd(input logic [1:0] rs, input byte_t e);
    acc(rs, 1'h0, 8'h00, q);
    chk(q, e);
  endtask
  task automatic vp();
    vertical_sync_pulse <= 1'h1;
    cyc(12);
    vertical_sync_pulse <= 1'h0;
    cyc(24);
  endtask
  task automatic pp();
    pen_pulse <= 1'h1;
    cyc(24);
    pen_pulse <= 1'h0;
    cyc(24);
  endtask
  // Status levels on port A: busy, error, inverted switch
  task automatic t_status();
    rd(`RS_PORTA, 8'hE0);
    printer_busy <= 1'h1;
    printer_error <= 1'h1;
    pen_switch_input <= 1'h1;
    cyc(20);
    rd(`RS_PORTA, 8'hA9);
    printer_busy <= 1'h0;
    printer_error <= 1'h0;
    pen_switch_input <= 1'h0;
  endtask
  task automatic t_decode();
    for (int a = 0; a < 257; a++) begin
      @(posedge core_clk);
      io_cycle <= (a < 256);
      io_addr <= 8'(a);
      @(negedge core_clk);
      chk(8'(adapter_chip_select), 8'(a < 256 && a[7:2] == 6'h38));
    end
    io_cycle <= 1'h0;
  endtask
  // Stalled printer: buffer fills, refuses a third byte, then drains in order
  task automatic t_print();
    int n;
    wr(`RS_PORTA, 8'hB2);
    chk(8'(printer_init_n), 8'h00);
    wr(`RS_PORTA, 8'hA2);
    chk(8'(printer_init_n), 8'h01);
    stall <= 1'h1;
    wr(`RS_PORTB, 8'h10);
    wr(`RS_PORTB, 8'h20);
    chk(8'(data_ready), 8'h00);
    wr(`RS_PORTB, 8'h30);
    chk(8'(printer_strobe_n), 8'h01);
    stall <= 1'h0;
    for (int k = 0; k < 2; k++) begin
      for (n = 0; n < 500 && printer_strobe_n !== 1'h0; n++) @(negedge core_clk);
      chk(printer_data_line, (k == 1) ? 8'h22 : 8'h12);
      for (n = 0; n < 500 && printer_strobe_n === 1'h0; n++) @(negedge core_clk);
      chk(8'(n), 8'(SL * 8));
    end
    cyc(200);
    chk(8'(tx_valid), 8'h00);
  endtask
  // Acknowledge interrupt enabled, then masked; busy edge interrupt
  task automatic t_ack();
    wr(`RS_CTRLB, 8'h03);
    acc(`RS_PORTB, 1'h0, 8'h00, q);
    wr(`RS_PORTB, 8'h44);
    cyc(200);
    chk(8'(printer_interrupt), 8'h01);
    rd(`RS_CTRLB, 8'h83);
    acc(`RS_PORTB, 1'h0, 8'h00, q);
    chk(8'(printer_interrupt), 8'h00);
    wr(`RS_CTRLB, 8'h02);
    wr(`RS_PORTB, 8'h48);
    cyc(200);
    chk(8'(printer_interrupt), 8'h00);
    rd(`RS_CTRLB, 8'h82);
    wr(`RS_CTRLB, 8'h18);
    acc(`RS_PORTB, 1'h0, 8'h00, q);
    printer_busy <= 1'h1;
    cyc(40);
    chk(8'(printer_interrupt), 8'h01);
    rd(`RS_PORTA, 8'hE3);
    rd(`RS_CTRLB, 8'h58);
    printer_busy <= 1'h0;
    cyc(20);
    rd(`RS_PORTA, 8'hE2);
    // Other acknowledge polarity, falling edge selected
    ack_active_high <= 1'h0;
    wr(`RS_CTRLB, 8'h01);
    acc(`RS_PORTB, 1'h0, 8'h00, q);
    wr(`RS_PORTB, 8'h4C);
    cyc(200);
    chk(8'(printer_interrupt), 8'h01);
    rd(`RS_CTRLB, 8'h81);
  endtask
  // Pen latch: sets, holds, interrupts, clears; trailing jumper delays set
  task automatic t_pen();
    wr(`RS_CTRLA, 8'h03);
    pp();
    chk(8'(light_pen_strobe), 8'h01);
    chk(8'(display_interrupt), 8'h01);
    rd(`RS_CTRLA, 8'h83);
    acc(`RS_PORTA, 1'h0, 8'h00, q);
    chk(8'(display_interrupt), 8'h00);
    wr(`RS_PORTA, 8'h82);
    wr(`RS_PORTA, 8'hA2);
    chk(8'(light_pen_strobe), 8'h00);
    pen_trailing_jumper <= 1'h1;
    pen_pulse <= 1'h1;
    cyc(24);
    chk(8'(light_pen_strobe), 8'h00);
    pen_pulse <= 1'h0;
    cyc(24);
    chk(8'(light_pen_strobe), 8'h01);
    wr(`RS_PORTA, 8'h82);
    wr(`RS_PORTA, 8'hA2);
    acc(`RS_PORTA, 1'h0, 8'h00, q);
  endtask
  // Video latch: interrupt, no repeat while set, clear rearms
  task automatic t_vsync();
    wr(`RS_CTRLA, 8'h18);
    vp();
    chk(8'(display_interrupt), 8'h01);
    rd(`RS_CTRLA, 8'h58);
    acc(`RS_PORTA, 1'h0, 8'h00, q);
    vp();
    chk(8'(display_interrupt), 8'h00);
    wr(`RS_PORTA, 8'h22);
    wr(`RS_PORTA, 8'hA2);
    vp();
    chk(8'(display_interrupt), 8'h01);
  endtask
  task automatic results();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    cyc(20);
    sys_rst <= 1'h0;
    cyc(2);
    t_status();
    t_decode();
    t_print();
    t_ack();
    t_pen();
    t_vsync();
    results();
  end
  // Run needs a few thousand cycles; cut off far beyond that
  initial begin
    #300000;
    error_cnt++;
    results();
  end
endmodule
bind printer_lightpen_vsync_port pport_props #(.STROBE_LEN(STROBE_LEN)) chk_u (.core_clk,
  .sys_rst, .enable_clk, .io_cycle, .io_addr, .rdata, .adapter_chip_select,
  .porta_interrupt_out, .portb_interrupt_out, .display_interrupt, .printer_interrupt,
  .printer_data_line, .printer_strobe_n, .pen_pulse, .pen_trailing_jumper,
  .light_pen_strobe, .data_ready, .tx_valid);
`default_nettype wire
